// ### design/ast_pkg.sv
// constants and types for the conversion sequence timing control block
package ast_pkg;
    localparam int ADDR_W = 3;
    localparam logic [2:0] SEQ_CTRL_OFS = 3'h3;
    localparam logic [2:0] TIMING_CTRL_OFS = 3'h4;
    localparam logic [2:0] START_OFS = 3'h5;
    localparam logic [2:0] STATUS_OFS = 3'h6;
    localparam logic [2:0] RESULT_OFS = 3'h7;
    localparam logic [7:0] SEQ_CTRL_RST = 8'h20;
    localparam logic [7:0] TIMING_CTRL_RST = 8'h05;
    localparam logic [1:0] RES_RST = 2'h2;
    localparam int SEQ_LEN_LSB = 3;
    localparam int FRZ_LSB = 0;
    localparam int SMP_LSB = 5;
    localparam int PRS_LSB = 0;
    localparam int RES_LSB = 6;
    localparam int CONV_CYCLES = 12;
    localparam logic [11:0] FULL_8 = 12'h0FF;
    localparam logic [11:0] FULL_10 = 12'h3FF;
    localparam logic [11:0] FULL_12 = 12'hFFF;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10
    } ast_state_e;
    typedef enum logic [1:0] {
        FRZ_RUN = 2'b00,
        FRZ_RSVD = 2'b01,
        FRZ_FINISH = 2'b10,
        FRZ_NOW = 2'b11
    } ast_frz_e;
endpackage : ast_pkg

// ### design/ast_clk_if.sv
// carrier between prescaler and sequencer
`timescale 1ns/1ps
interface ast_clk_if;
    logic [4:0] prescale;
    logic run;
    logic tick;
    logic conv_clk;
    modport gen (input prescale, input run, output tick, output conv_clk);
    modport use_side (output prescale, output run, input tick,
        input conv_clk);
endinterface : ast_clk_if

// ### design/ast_prescaler.sv
// conversion clock prescaler
`timescale 1ns/1ps
module ast_prescaler (
    input wire logic clk,
    input wire logic rst,
    ast_clk_if.gen cif
);
    logic [4:0] cnt_r;
    logic phase_r;
    // tick marks one conversion clock period, on the falling half end
    assign cif.tick = cif.run && (cnt_r == cif.prescale) && phase_r;
    assign cif.conv_clk = phase_r;
    always_ff @(posedge clk) begin
        if (rst || !cif.run) begin
            cnt_r <= 5'h00;
            phase_r <= 1'b0;
        end else if (cnt_r >= cif.prescale) begin
            cnt_r <= 5'h00;
            phase_r <= ~phase_r;
        end else begin
            cnt_r <= cnt_r + 5'h01;
        end
    end
endmodule : ast_prescaler

// ### design/ast_top.sv
// conversion sequence timing control top
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module ast_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic debug_freeze,
    output logic conv_clk,
    output logic sampling,
    output logic converting,
    output logic seq_busy,
    output logic seq_done,
    output logic [3:0] conv_index,
    output logic [11:0] result
);
    ast_clk_if cif ();
    ast_prescaler u_pre (
        .clk(clk),
        .rst(rst),
        .cif(cif)
    );

    logic [7:0] seq_ctrl_r;
    logic [7:0] timing_ctrl_r;
    logic [1:0] res_r;
    logic freeze_s1_r;
    logic freeze_s2_r;
    ast_pkg::ast_state_e state_r;
    logic [4:0] phase_cnt_r;
    logic [3:0] conv_cnt_r;
    logic [3:0] seq_len;
    logic [4:0] smp_len;
    logic halt;
    logic abort;
    logic start;
    logic frz_pending_r;
    logic done_r;
    logic [11:0] result_r;
    logic [7:0] rdata_r;

    // debug freeze comes from another block, so it is synchronised
    always_ff @(posedge clk) begin
        if (rst) begin
            freeze_s1_r <= 1'b0;
            freeze_s2_r <= 1'b0;
        end else begin
            freeze_s1_r <= debug_freeze;
            freeze_s2_r <= freeze_s1_r;
        end
    end

    always_comb begin
        logic [3:0] code;
        code = seq_ctrl_r[ast_pkg::SEQ_LEN_LSB +: 4];
        if (code[3] || code == 4'h0) begin
            seq_len = 4'h8;
        end else begin
            seq_len = code;
        end
    end

    always_comb begin
        unique case (timing_ctrl_r[ast_pkg::SMP_LSB +: 3])
            3'h0: smp_len = 5'h04;
            3'h1: smp_len = 5'h06;
            3'h2: smp_len = 5'h08;
            3'h3: smp_len = 5'h0A;
            3'h4: smp_len = 5'h0C;
            3'h5: smp_len = 5'h10;
            3'h6: smp_len = 5'h14;
            3'h7: smp_len = 5'h18;
        endcase
    end

    // reserved code 01 behaves like continue
    always_comb begin
        ast_pkg::ast_frz_e frz;
        frz = ast_pkg::ast_frz_e'(seq_ctrl_r[ast_pkg::FRZ_LSB +: 2]);
        halt = 1'b0;
        if (freeze_s2_r) begin
            if (frz == ast_pkg::FRZ_NOW) begin
                halt = 1'b1;
            end else if (frz == ast_pkg::FRZ_FINISH) begin
                halt = frz_pending_r || state_r == ast_pkg::ST_IDLE;
            end
        end
    end

    // any write to the sequence control, timing control or start register aborts
    assign abort = wr && (addr == ast_pkg::TIMING_CTRL_OFS
        || addr == ast_pkg::SEQ_CTRL_OFS || addr == ast_pkg::START_OFS);
    assign start = wr && addr == ast_pkg::START_OFS;
    assign cif.prescale = timing_ctrl_r[ast_pkg::PRS_LSB +: 5];
    assign cif.run = state_r != ast_pkg::ST_IDLE && !halt;

    always_ff @(posedge clk) begin
        if (rst) begin
            seq_ctrl_r <= ast_pkg::SEQ_CTRL_RST;
            timing_ctrl_r <= ast_pkg::TIMING_CTRL_RST;
            res_r <= ast_pkg::RES_RST;
        end else if (wr) begin
            if (addr == ast_pkg::SEQ_CTRL_OFS) begin
                seq_ctrl_r <= wdata;
            end
            if (addr == ast_pkg::TIMING_CTRL_OFS) begin
                timing_ctrl_r <= wdata;
            end
            if (addr == ast_pkg::START_OFS) begin
                res_r <= wdata[ast_pkg::RES_LSB +: 2];
            end
        end
    end

    // finish-then-freeze: latch the halt once the ongoing conversion ends
    always_ff @(posedge clk) begin
        if (rst || !freeze_s2_r || abort) begin
            frz_pending_r <= 1'b0;
        end else if (state_r == ast_pkg::ST_CONVERT && cif.tick
            && phase_cnt_r == 5'(ast_pkg::CONV_CYCLES - 1)) begin
            frz_pending_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || abort) begin
            state_r <= ast_pkg::ST_IDLE;
            phase_cnt_r <= 5'h00;
            conv_cnt_r <= 4'h0;
            if (start && !rst) begin
                state_r <= ast_pkg::ST_SAMPLE;
            end
        end else if (cif.tick) begin
            unique case (state_r)
                ast_pkg::ST_IDLE: begin
                    phase_cnt_r <= 5'h00;
                end
                ast_pkg::ST_SAMPLE: begin
                    if (phase_cnt_r == smp_len - 5'h01) begin
                        phase_cnt_r <= 5'h00;
                        state_r <= ast_pkg::ST_CONVERT;
                    end else begin
                        phase_cnt_r <= phase_cnt_r + 5'h01;
                    end
                end
                ast_pkg::ST_CONVERT: begin
                    if (phase_cnt_r == 5'(ast_pkg::CONV_CYCLES - 1)) begin
                        phase_cnt_r <= 5'h00;
                        if (conv_cnt_r + 4'h1 == seq_len) begin
                            state_r <= ast_pkg::ST_IDLE;
                            conv_cnt_r <= 4'h0;
                        end else begin
                            state_r <= ast_pkg::ST_SAMPLE;
                            conv_cnt_r <= conv_cnt_r + 4'h1;
                        end
                    end else begin
                        phase_cnt_r <= phase_cnt_r + 5'h01;
                    end
                end
                default: state_r <= ast_pkg::ST_IDLE;
            endcase
        end
    end

    // no analog front end here: each result is a full-scale test code
    always_ff @(posedge clk) begin
        if (rst) begin
            done_r <= 1'b0;
            result_r <= 12'h000;
        end else begin
            done_r <= 1'b0;
            if (!abort && cif.tick && state_r == ast_pkg::ST_CONVERT
                && phase_cnt_r == 5'(ast_pkg::CONV_CYCLES - 1)) begin
                unique case (res_r)
                    2'b00: result_r <= ast_pkg::FULL_8;
                    2'b01: result_r <= ast_pkg::FULL_10;
                    default: result_r <= ast_pkg::FULL_12;
                endcase
                done_r <= conv_cnt_r + 4'h1 == seq_len;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                ast_pkg::SEQ_CTRL_OFS: rdata_r <= seq_ctrl_r;
                ast_pkg::TIMING_CTRL_OFS: rdata_r <= timing_ctrl_r;
                ast_pkg::START_OFS: rdata_r <= {res_r, 6'h00};
                ast_pkg::STATUS_OFS: rdata_r <= {2'b00, halt,
                    state_r != ast_pkg::ST_IDLE, conv_cnt_r};
                ast_pkg::RESULT_OFS: rdata_r <= result_r[11:4];
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign rdata = rdata_r;
    assign conv_clk = cif.conv_clk;
    assign sampling = state_r == ast_pkg::ST_SAMPLE;
    assign converting = state_r == ast_pkg::ST_CONVERT;
    assign seq_busy = state_r != ast_pkg::ST_IDLE;
    assign seq_done = done_r;
    assign conv_index = conv_cnt_r;
    assign result = result_r;
endmodule : ast_top

// ### testbench/ast_top_assertions.sv
// port checker for the timing control block
`timescale 1ns/1ps
module ast_top_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic debug_freeze,
    input wire logic conv_clk,
    input wire logic sampling,
    input wire logic converting,
    input wire logic seq_busy,
    input wire logic seq_done,
    input wire logic [3:0] conv_index,
    input wire logic [11:0] result
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_abort; wr && addr == 3'h4 |=> !seq_busy; endproperty
    a_abort: assert property (p_abort) else $error("busy after abort");
    property p_rdata; !rd |=> rdata == 8'h00; endproperty
    a_rdata: assert property (p_rdata) else $error("stray read data");
    // freeze is synced over two flops, so look back that far
    property p_start; wr && addr == 3'h5 && !debug_freeze
        && !$past(debug_freeze) && !$past(debug_freeze, 2)
        |=> seq_busy && sampling; endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_idle; !seq_busy && !$past(seq_busy) |-> !conv_clk; endproperty
    a_idle: assert property (p_idle) else $error("clock while idle");
    property p_excl; !(sampling && converting); endproperty
    a_excl: assert property (p_excl) else $error("two phases");
    property p_order; $rose(converting) |-> $past(sampling); endproperty
    a_order: assert property (p_order) else $error("no sample");
    property p_done; seq_done |-> $past(converting) ##1 !seq_done; endproperty
    a_done: assert property (p_done) else $error("bad done");
    property p_idx; seq_busy |-> conv_index < 4'h8; endproperty
    a_idx: assert property (p_idx) else $error("index range");
    property p_res;
        result inside {12'h000, 12'h0FF, 12'h3FF, 12'hFFF}; endproperty
    a_res: assert property (p_res) else $error("result code");
    c_done: cover property (seq_done);
    c_conv: cover property ($rose(converting));
    c_abort: cover property (wr && addr == 3'h4 && seq_busy);
endmodule : ast_top_assertions
bind ast_top ast_top_assertions u_ast_top_assertions (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .debug_freeze(debug_freeze), .conv_clk(conv_clk), .sampling(sampling),
    .converting(converting), .seq_busy(seq_busy), .seq_done(seq_done),
    .conv_index(conv_index), .result(result));

// ### testbench/ast_top_tb.sv
// self-checking bench for the timing control block
`timescale 1ns/1ps
module ast_top_tb;
    logic clk, rst, wr, rd, debug_freeze, conv_clk, sampling, converting;
    logic seq_busy, seq_done;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    logic [3:0] conv_index;
    logic [11:0] result;
    logic [7:0] snap;
    int n_fail = 0;
    int n_tests = 0;
    int smp_tab[8] = '{4, 6, 8, 10, 12, 16, 20, 24};
    logic [3:0] lc[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8, 4'hC, 4'hF};
    int nc[8] = '{8, 1, 2, 3, 7, 8, 8, 8};
    ast_top u_ast_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .debug_freeze(debug_freeze),
        .conv_clk(conv_clk), .sampling(sampling), .converting(converting),
        .seq_busy(seq_busy), .seq_done(seq_done), .conv_index(conv_index),
        .result(result));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task check(input string what, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task conclude;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    // a gap cycle after each strobe keeps one assignment per time step
    task wr_reg(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    task rd_reg(input logic [2:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check("rdata", {8'h00, rdata}, {8'h00, exp});
        @(posedge clk);
    endtask : rd_reg
    task run(input logic [7:0] sc, tc, st, input int n, input logic frz);
        int cnt, rises;
        logic prev;
        cnt = 0;
        rises = 0;
        prev = 1'b0;
        debug_freeze <= frz;
        wr_reg(3'h3, sc);
        wr_reg(3'h4, tc);
        // start written here so the first sample cycle is counted too
        addr <= 3'h5;
        wdata <= st;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
        for (int k = 0; k < 6000; k++) begin
            if (seq_done === 1'b1) break;
            if (sampling === 1'b1) cnt++;
            if (sampling === 1'b1 && prev !== 1'b1) rises++;
            prev = sampling;
            @(posedge clk);
            #1;
        end
        check("convs", 16'(rises), 16'(n));
        check("smp", 16'(cnt),
            16'(n * smp_tab[tc[7:5]] * 2 * (tc[4:0] + 1)));
        check("res", {4'h0, result}, {4'h0, (st[7:6] == 2'b00 ?
            ast_pkg::FULL_8 : st[7:6] == 2'b01 ? ast_pkg::FULL_10 :
            ast_pkg::FULL_12)});
    endtask : run
    initial begin
        repeat (30000) @(posedge clk);
        n_fail++;
        conclude;
    end
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        debug_freeze = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_reg(3'h3, 8'h20);
        rd_reg(3'h4, 8'h05);
        rd_reg(3'h0, 8'h00);
        wr_reg(3'h4, 8'hA7);
        rd_reg(3'h4, 8'hA7);
        // freeze only beside the run-on codes; halting codes run unfrozen
        for (int i = 0; i < 8; i++) begin
            run({1'b0, lc[i], 1'b0, 2'(i % 4)}, {3'(i), 5'(i % 3)},
                {2'(i % 3), 6'h00}, nc[i], i % 4 < 2);
        end
        rd_reg(3'h7, ast_pkg::FULL_10[11:4]);
        rd_reg(3'h5, 8'h40);
        wr_reg(3'h3, 8'h13);
        wr_reg(3'h5, 8'h80);
        debug_freeze <= 1'b1;
        repeat (4) @(posedge clk);
        #1 snap = {conv_clk, sampling, converting, seq_busy, conv_index};
        repeat (30) @(posedge clk);
        #1 check("halt", {8'h00, conv_clk, sampling, converting, seq_busy,
            conv_index}, {8'h00, snap});
        check("busy", {15'h0000, seq_busy}, 16'h0001);
        rd_reg(3'h6, 8'h30);
        wr_reg(3'h4, 8'h05);
        #1 check("abort", {15'h0000, seq_busy}, 16'h0000);
        debug_freeze <= 1'b0;
        wr_reg(3'h3, 8'h12);
        wr_reg(3'h5, 8'h80);
        debug_freeze <= 1'b1;
        repeat (300) @(posedge clk);
        // held at the start of the second sample phase
        #1 check("finish", {13'h0000, sampling, converting, seq_busy},
            16'h0005);
        check("finidx", {12'h000, conv_index}, 16'h0001);
        rd_reg(3'h6, 8'h31);
        conclude;
    end
endmodule : ast_top_tb
